// ===== common/ccfa_pkg.sv
// Package: constants for the condition flag and addressing block
package ccfa_pkg;
  localparam int DATA_W = 8;
  localparam int PTR_BYTES = 2;
  localparam int PTR_W = 8 * PTR_BYTES;
  localparam int PC_W = 17;
  // Operation codes from the decoder
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_SUB = 3'h1;
  localparam logic [2:0] OP_AND = 3'h2;
  localparam logic [2:0] OP_OR = 3'h3;
  localparam logic [2:0] OP_XOR = 3'h4;
  localparam logic [2:0] OP_PASS = 3'h5;
  // Instruction classes
  localparam logic [1:0] INS_OTHER = 2'h0;
  localparam logic [1:0] INS_BYTE_MOVE = 2'h1;
  localparam logic [1:0] INS_WORD_MOVE = 2'h2;
  // Flag vector bit positions
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [PTR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [PC_W-1:0] PC_RST = 17'h0_0000;
endpackage : ccfa_pkg

// ===== verif/ccfa_core_tb_top.sv
// Testbench for the condition flag and addressing core
`timescale 1ns/1ns
module ccfa_core_tb_top;
  import ccfa_pkg::*;
  logic         mclk, sys_rst, exec_valid, exec_cin, mem_valid, mem_reuse;
  logic         stack_pointer_we, pc_load, pc_step, pc_half;
  logic [2:0]   exec_op;
  logic [1:0]   mem_ins;
  logic [7:0]   exec_opa, exec_opb, result_r;
  logic [15:0]  mem_addr, stack_pointer_wdata, oper_addr_r, stack_pointer;
  logic [16:0]  pc_wdata, pc_r;
  logic         result_zero_flag, carry_borrow_flag, sign_flag;
  logic         signed_overflow_flag, av, rj, phb;
  logic [3:0]   flags_seen;
  int           num_errors, checks_done;
  // ==========================================================
  // Design and clock
  ccfa_core #(.W(DATA_W)) ccfa_core_inst (.mclk(mclk), .sys_rst(sys_rst),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_opa(exec_opa),
    .exec_opb(exec_opb), .exec_cin(exec_cin), .mem_valid(mem_valid),
    .mem_ins(mem_ins), .mem_reuse(mem_reuse), .mem_addr(mem_addr),
    .stack_pointer_we(stack_pointer_we),
    .stack_pointer_wdata(stack_pointer_wdata), .pc_load(pc_load),
    .pc_wdata(pc_wdata), .pc_step(pc_step), .pc_half(pc_half),
    .result_r(result_r), .result_zero_flag(result_zero_flag),
    .carry_borrow_flag(carry_borrow_flag), .sign_flag(sign_flag),
    .signed_overflow_flag(signed_overflow_flag),
    .oper_addr_r(oper_addr_r), .oper_addr_valid_r(av),
    .reuse_reject_r(rj), .stack_pointer(stack_pointer), .pc_r(pc_r),
    .pc_half_byte_r(phb));
  assign flags_seen = {signed_overflow_flag, sign_flag, carry_borrow_flag,
                       result_zero_flag};
  always #50 mclk = ~mclk;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [16:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  // Inputs change 1 ns after the edge so the design samples them settled
  task automatic cyc;
    @(posedge mclk);
    #1;
  endtask : cyc
  task automatic alu(input logic [2:0] op, input logic [7:0] a, b,
                     input logic ci, input logic [7:0] r, input logic [3:0] f);
    exec_valid = 1'b1; exec_op = op; exec_opa = a; exec_opb = b; exec_cin = ci;
    cyc;
    // Strobe stays high between calls; the scenario lowers it at its end
    chk("result", {9'h000, r}, {9'h000, result_r});
    chk("flags vncz", {13'h0000, f}, {13'h0000, flags_seen});
  endtask : alu
  task automatic mem(input logic [1:0] ins, input logic ru,
                     input logic [15:0] a, e, input logic ev, er);
    mem_valid = 1'b1; mem_ins = ins; mem_reuse = ru; mem_addr = a;
    cyc;
    chk("oper addr", {1'b0, e}, {1'b0, oper_addr_r});
    chk("valid reject", {15'h0000, ev, er}, {15'h0000, av, rj});
  endtask : mem
  // ==========================================================
  // Scenarios
  task automatic test_flags;
    alu(OP_ADD, 8'h7F, 8'h01, 1'b0, 8'h80, 4'b1100);
    alu(OP_ADD, 8'hFF, 8'h01, 1'b0, 8'h00, 4'b0011);
    alu(OP_ADD, 8'hFE, 8'h01, 1'b1, 8'h00, 4'b0011);
    alu(OP_SUB, 8'h00, 8'h01, 1'b0, 8'hFF, 4'b0110);
    alu(OP_SUB, 8'h80, 8'h01, 1'b0, 8'h7F, 4'b1000);
    alu(OP_SUB, 8'h05, 8'h05, 1'b0, 8'h00, 4'b0001);
    alu(OP_AND, 8'hF0, 8'h0F, 1'b0, 8'h00, 4'b0001);
    alu(OP_OR,  8'h80, 8'h01, 1'b0, 8'h81, 4'b0100);
    alu(OP_XOR, 8'hFF, 8'h7E, 1'b0, 8'h81, 4'b0100);
    alu(OP_PASS, 8'h00, 8'h01, 1'b0, 8'h01, 4'b0000);
    exec_valid = 1'b0;
  endtask : test_flags
  task automatic test_handy;
    mem(INS_BYTE_MOVE, 1'b0, 16'h1234, 16'h1234, 1'b1, 1'b0);
    mem(INS_WORD_MOVE, 1'b1, 16'hFFFF, 16'h1234, 1'b1, 1'b0);
    mem(INS_OTHER, 1'b1, 16'h0F0F, 16'h1234, 1'b0, 1'b1);
    mem(INS_BYTE_MOVE, 1'b1, 16'h0000, 16'h1234, 1'b1, 1'b0);
    mem(INS_OTHER, 1'b0, 16'hABCD, 16'hABCD, 1'b1, 1'b0);
    mem(INS_WORD_MOVE, 1'b1, 16'h5555, 16'hABCD, 1'b1, 1'b0);
    mem_valid = 1'b0;
    cyc;
    chk("valid pulse end", 17'h0_0000, {15'h0000, av, rj});
  endtask : test_handy
  task automatic test_pc;
    pc_load = 1'b1; pc_wdata = 17'h1_0010;
    cyc;
    pc_load = 1'b0; pc_step = 1'b1; pc_half = 1'b1;
    cyc;
    chk("pc half step", 17'h1_0011, pc_r);
    chk("half byte", 17'h0_0001, {16'h0000, phb});
    pc_half = 1'b0;
    cyc;
    chk("pc full step", 17'h1_0013, pc_r);
    pc_load = 1'b1; pc_wdata = 17'h0_0002;
    cyc;
    pc_load = 1'b0; pc_step = 1'b0;
    chk("pc load wins", 17'h0_0002, {pc_r[16:1], phb});
  endtask : test_pc
  task automatic test_stack_pointer;
    stack_pointer_we = 1'b1; stack_pointer_wdata = 16'hA55A;
    cyc;
    chk("stack pointer", 17'h0_A55A, {1'b0, stack_pointer});
    stack_pointer_wdata = 16'h5AA5;
    cyc;
    stack_pointer_we = 1'b0;
    chk("stack pointer", 17'h0_5AA5, {1'b0, stack_pointer});
  endtask : test_stack_pointer
  // Mid-run reset clears everything but the stack pointer
  task automatic test_reset;
    pc_load = 1'b1; pc_wdata = 17'h0_0005;
    exec_valid = 1'b1; exec_op = OP_ADD; exec_opa = 8'h7F; exec_opb = 8'h01;
    exec_cin = 1'b0;
    cyc;
    pc_load = 1'b0; exec_valid = 1'b0; sys_rst = 1'b1;
    cyc;
    sys_rst = 1'b0;
    chk("reset result", 17'h0_0000, {9'h000, result_r});
    chk("reset flags", 17'h0_0000, {13'h0000, flags_seen});
    chk("reset pc", PC_RST, pc_r);
    chk("reset pulses", 17'h0_0000, {15'h0000, av, rj});
    chk("stack pointer kept", 17'h0_5AA5, {1'b0, stack_pointer});
    alu(OP_SUB, 8'h10, 8'h01, 1'b1, 8'h0E, 4'b0000);
    exec_valid = 1'b0;
    cyc;
  endtask : test_reset
  // ==========================================================
  // Sequence, verdict and watchdog
  task automatic test_done;
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    mclk = 1'b0; sys_rst = 1'b1; exec_valid = 1'b0; exec_cin = 1'b0;
    exec_op = 3'h0; exec_opa = 8'h00; exec_opb = 8'h00; mem_valid = 1'b0;
    mem_ins = 2'h0; mem_reuse = 1'b0; mem_addr = 16'h0000;
    stack_pointer_we = 1'b0; stack_pointer_wdata = 16'h0000;
    pc_load = 1'b0; pc_wdata = 17'h0_0000;
    pc_step = 1'b0; pc_half = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    chk("reset flags", 17'h0_0000, {13'h0000, flags_seen});
    test_flags;
    test_handy;
    test_pc;
    test_stack_pointer;
    test_reset;
    test_done;
  end
  // The whole run takes about 33 cycles, so 2000 leaves wide margin
  initial begin
    #(100 * 2000);
    num_errors++;
    test_done;
  end
endmodule : ccfa_core_tb_top

// ===== verilog/ccfa_alu.sv
// Combinational ALU producing result and condition flags
`timescale 1ns/1ns
module ccfa_alu #(
  parameter int W = 8
) (
  input  wire logic [2:0]   op,
  input  wire logic [W-1:0] opa,
  input  wire logic [W-1:0] opb,
  input  wire logic         cin,
  output logic [W-1:0]      res,
  output logic [3:0]        flags
);
  import ccfa_pkg::*;
  // Sign and carry need at least two result bits
  if (W < 2) begin : g_width_check
    $error("ccfa_alu: W must be at least 2");
  end
  logic [W:0] sum;
  logic       arith;
  always_comb begin
    sum = '0;
    arith = 1'b0;
    case (op)
      OP_ADD: begin
        sum = {1'b0, opa} + {1'b0, opb} + {{W{1'b0}}, cin};
        arith = 1'b1;
      end
      OP_SUB: begin
        sum = {1'b0, opa} - {1'b0, opb} - {{W{1'b0}}, cin};
        arith = 1'b1;
      end
      OP_AND: sum = {1'b0, opa & opb};
      OP_OR: sum = {1'b0, opa | opb};
      OP_XOR: sum = {1'b0, opa ^ opb};
      default: sum = {1'b0, opb};
    endcase
    res = sum[W-1:0];
    flags[FLAG_Z] = (sum[W-1:0] == '0);
    flags[FLAG_C] = arith & sum[W];
    flags[FLAG_N] = sum[W-1];
    // Signed overflow: operands agree in sign on add, differ on subtract, and result sign differs from opa
    if (op == OP_ADD)
      flags[FLAG_V] = (opa[W-1] == opb[W-1]) && (sum[W-1] != opa[W-1]);
    else if (op == OP_SUB)
      flags[FLAG_V] = (opa[W-1] != opb[W-1]) && (sum[W-1] != opa[W-1]);
    else
      flags[FLAG_V] = 1'b0;
  end
endmodule : ccfa_alu

// ===== verilog/ccfa_core.sv
// Condition flags, reused address, pointer and program counter state
`timescale 1ns/1ns
module ccfa_core #(
  parameter int W = 8
) (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic                      exec_valid,
  input  wire logic [2:0]                exec_op,
  input  wire logic [W-1:0]              exec_opa,
  input  wire logic [W-1:0]              exec_opb,
  input  wire logic                      exec_cin,
  input  wire logic                      mem_valid,
  input  wire logic [1:0]                mem_ins,
  input  wire logic                      mem_reuse,
  input  wire logic [ccfa_pkg::PTR_W-1:0] mem_addr,
  input  wire logic                      stack_pointer_we,
  input  wire logic [ccfa_pkg::PTR_W-1:0] stack_pointer_wdata,
  input  wire logic                      pc_load,
  input  wire logic [ccfa_pkg::PC_W-1:0] pc_wdata,
  input  wire logic                      pc_step,
  input  wire logic                      pc_half,
  output logic [W-1:0]                   result_r,
  output logic                           result_zero_flag,
  output logic                           carry_borrow_flag,
  output logic                           sign_flag,
  output logic                           signed_overflow_flag,
  output logic [ccfa_pkg::PTR_W-1:0]     oper_addr_r,
  output logic                           oper_addr_valid_r,
  output logic                           reuse_reject_r,
  output logic [ccfa_pkg::PTR_W-1:0]     stack_pointer,
  output logic [ccfa_pkg::PC_W-1:0]      pc_r,
  output logic                           pc_half_byte_r
);
  import ccfa_pkg::*;

  // Flag positions and operand slicing assume the byte-wide datapath
  if (W != DATA_W) begin : g_width_check
    $error("ccfa_core: W must equal DATA_W");
  end

  // ====================================================================
  // State
  typedef struct packed {
    logic [W-1:0]     result;
    logic [3:0]       flags;
    logic [PTR_W-1:0] last_addr;
    logic [PTR_W-1:0] oper_addr;
    logic             oper_valid;
    logic             reject;
    logic [PC_W-1:0]  pc;
    logic [PTR_W-1:0] stack_ptr;
  } ccfa_state_type;

  ccfa_state_type st_r;
  ccfa_state_type st_nxt;

  logic [W-1:0] alu_res;
  logic [3:0]   alu_flags;

  ccfa_alu #(.W(W)) u_alu (
    .op    (exec_op),
    .opa   (exec_opa),
    .opb   (exec_opb),
    .cin   (exec_cin),
    .res   (alu_res),
    .flags (alu_flags)
  );

  logic move_ins;
  assign move_ins = (mem_ins == INS_BYTE_MOVE) || (mem_ins == INS_WORD_MOVE);

  // ====================================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.oper_valid = 1'b0;
    st_nxt.reject = 1'b0;
    if (exec_valid) begin
      st_nxt.result = alu_res;
      st_nxt.flags = alu_flags;
    end
    if (mem_valid) begin
      if (mem_reuse && !move_ins) begin
        st_nxt.reject = 1'b1;
      end else if (mem_reuse) begin
        st_nxt.oper_addr = st_r.last_addr;
        st_nxt.oper_valid = 1'b1;
      end else begin
        st_nxt.oper_addr = mem_addr;
        st_nxt.last_addr = mem_addr;
        st_nxt.oper_valid = 1'b1;
      end
    end
    // PC counts in half bytes; the LSB selects the nibble
    if (pc_load)
      st_nxt.pc = pc_wdata;
    else if (pc_step)
      st_nxt.pc = st_r.pc + (pc_half ? PC_W'(1) : PC_W'(2));
    if (stack_pointer_we) begin
      st_nxt.stack_ptr = stack_pointer_wdata;
    end
    // Reset skips the stack pointer: it powers up unknown until loaded
    if (sys_rst) begin
      st_nxt.result = '0;
      st_nxt.flags = FLAGS_RST;
      st_nxt.last_addr = ADDR_RST;
      st_nxt.oper_addr = ADDR_RST;
      st_nxt.oper_valid = 1'b0;
      st_nxt.reject = 1'b0;
      st_nxt.pc = PC_RST;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign result_r = st_r.result;
  assign result_zero_flag = st_r.flags[FLAG_Z];
  assign carry_borrow_flag = st_r.flags[FLAG_C];
  assign sign_flag = st_r.flags[FLAG_N];
  assign signed_overflow_flag = st_r.flags[FLAG_V];
  assign oper_addr_r = st_r.oper_addr;
  assign oper_addr_valid_r = st_r.oper_valid;
  assign reuse_reject_r = st_r.reject;
  assign stack_pointer = st_r.stack_ptr;
  assign pc_r = st_r.pc;
  assign pc_half_byte_r = st_r.pc[0];

  // ====================================================================
  // Assertions
  sequence s_exec;
    exec_valid;
  endsequence

  AST_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
    s_exec |=> result_zero_flag == (result_r == '0))
    else $error("zero flag mismatch");
  AST_SIGN: assert property (@(posedge mclk) disable iff (sys_rst)
    s_exec |=> sign_flag == result_r[W-1])
    else $error("sign flag mismatch");
  AST_CARRY: assert property (@(posedge mclk) disable iff (sys_rst)
    exec_valid && exec_op == OP_ADD |=>
      carry_borrow_flag == (({1'b0, $past(exec_opa)} + {1'b0, $past(exec_opb)}
        + {{W{1'b0}}, $past(exec_cin)}) >> W))
    else $error("carry flag mismatch");
  AST_OVF: assert property (@(posedge mclk) disable iff (sys_rst)
    exec_valid && exec_op > OP_SUB |=> !signed_overflow_flag)
    else $error("overflow on logic op");
  AST_REUSE: assert property (@(posedge mclk) disable iff (sys_rst)
    mem_valid && mem_reuse && move_ins |=>
      oper_addr_valid_r && oper_addr_r == $past(st_r.last_addr))
    else $error("last address not reused");
  AST_REJECT: assert property (@(posedge mclk) disable iff (sys_rst)
    mem_valid && mem_reuse && !move_ins |=>
      reuse_reject_r && !oper_addr_valid_r)
    else $error("reuse accepted on non-move");
  AST_PCHALF: assert property (@(posedge mclk) disable iff (sys_rst)
    !pc_load && pc_step && pc_half |=> pc_half_byte_r != $past(pc_half_byte_r))
    else $error("half step did not toggle pc lsb");
  AST_STACK_PTR: assert property (@(posedge mclk)
    stack_pointer_we |=> stack_pointer == $past(stack_pointer_wdata))
    else $error("stack pointer write lost");
  AST_PCLOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    pc_load |=> pc_r == $past(pc_wdata))
    else $error("pc load lost");

  // Sign-extended sums give an overflow reference independent of the ALU
  logic [W:0] add_ext;
  logic [W:0] sub_ext;
  assign add_ext = {exec_opa[W-1], exec_opa} + {exec_opb[W-1], exec_opb}
                   + {{W{1'b0}}, exec_cin};
  assign sub_ext = {exec_opa[W-1], exec_opa} - {exec_opb[W-1], exec_opb}
                   - {{W{1'b0}}, exec_cin};

  AST_BORROW: assert property (@(posedge mclk) disable iff (sys_rst)
    exec_valid && exec_op == OP_SUB |=>
      carry_borrow_flag == ({1'b0, $past(exec_opa)} <
        {1'b0, $past(exec_opb)} + {{W{1'b0}}, $past(exec_cin)}))
    else $error("borrow flag mismatch");
  AST_OVF_ADD: assert property (@(posedge mclk) disable iff (sys_rst)
    exec_valid && exec_op == OP_ADD |=>
      signed_overflow_flag == $past(add_ext[W] ^ add_ext[W-1]))
    else $error("overflow flag mismatch on add");
  AST_OVF_SUB: assert property (@(posedge mclk) disable iff (sys_rst)
    exec_valid && exec_op == OP_SUB |=>
      signed_overflow_flag == $past(sub_ext[W] ^ sub_ext[W-1]))
    else $error("overflow flag mismatch on subtract");
  AST_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    !exec_valid |=> $stable({result_r, result_zero_flag, carry_borrow_flag,
      sign_flag, signed_overflow_flag}))
    else $error("flags changed without operation");
endmodule : ccfa_core
